// File: common/pcd_pkg.sv
// Constants for the PLL ratio configuration decoder.
// Assumes configuration fields arrive as plain ports, bit 0 as LSB.
package pcd_pkg;

    // ****************************************
    // Field widths and counts
    // ****************************************
    localparam int RATIO_W  = 5;
    localparam int SEL_W    = 4;
    localparam int SDR_W    = 3;
    localparam int LDIV_W   = 5;
    localparam int NCORE    = 4;
    localparam int NSERDES  = 3;
    localparam int NPLL     = 6;

    // ****************************************
    // Platform ratio codes
    // ****************************************
    localparam logic [4:0] PLAT_MIN = 5'h04;
    localparam logic [4:0] PLAT_MAX = 5'h0A;

    // ****************************************
    // Cluster ratio codes
    // ****************************************
    localparam logic [4:0] CLU_MIN  = 5'h08;
    localparam logic [4:0] CLU_MAX  = 5'h12;

    // ****************************************
    // Core select codes
    // ****************************************
    localparam logic [3:0] SEL_C1_D1 = 4'h0;
    localparam logic [3:0] SEL_C1_D2 = 4'h1;
    localparam logic [3:0] SEL_C2_D1 = 4'h4;
    localparam logic [3:0] SEL_C2_D2 = 4'h5;

    // ****************************************
    // Memory ratio codes
    // ****************************************
    localparam logic [4:0] MEM_SYNC_1TO1 = 5'h01;
    localparam logic [4:0] MEM_MIN       = 5'h05;
    localparam logic [4:0] MEM_MAX       = 5'h14;

    // ****************************************
    // Loop configuration values
    // ****************************************
    localparam logic [1:0] LOOP_HIGH = 2'h0;
    localparam logic [1:0] LOOP_LOW  = 2'h1;

    // ****************************************
    // Derived clock constants
    // ****************************************
    localparam logic [4:0] PME_DIV      = 5'h02;
    localparam logic [4:0] MEM_SYNC_DIV = 5'h02;
    localparam logic [4:0] DIV_ONE      = 5'h01;

    // ****************************************
    // Decoder states
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LATCH = 2'b01,
        ST_RUN   = 2'b10
    } pcd_state_type;

endpackage

// File: rtl/pcd_clk_div.sv
// Divide-by-N enable generator.
// Assumes a single system clock; divisor is held steady while enabled.
`timescale 1ns/10ps
module pcd_clk_div
    import pcd_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    // Control
    input  wire logic             run,
    input  wire logic [4:0]       divisor,
    // Output
    output logic                  tick
);

    logic [4:0] count;
    wire        wrap = (count >= divisor - DIV_ONE);
    wire  [4:0] next_count = wrap ? 5'h00 : count + DIV_ONE;

    always_ff @(posedge clk_sys) begin
        if (!rstn || !run || divisor == 5'h00) begin
            count <= 5'h00;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= wrap;
        end
    end

endmodule

// File: rtl/pcd_decode.sv
// PLL ratio configuration decoder and derived clock enables.
// Assumes reset configuration fields are stable while config_valid is high.
`timescale 1ns/10ps
module pcd_decode
    import pcd_pkg::*;
(
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    // Reset configuration word fields
    input  wire logic                       config_valid,
    input  wire logic [RATIO_W-1:0]         platform_ratio_field,
    input  wire logic [1:0]                 platform_loop_cfg,
    input  wire logic [RATIO_W-1:0]         cluster1_ratio_field,
    input  wire logic [RATIO_W-1:0]         cluster2_ratio_field,
    input  wire logic [1:0]                 cluster1_loop_cfg,
    input  wire logic [1:0]                 cluster2_loop_cfg,
    input  wire logic [NCORE*SEL_W-1:0]     core_clock_select,
    input  wire logic                       ddr_sync_select,
    input  wire logic [RATIO_W-1:0]         memory_ratio_field,
    input  wire logic [1:0]                 memory_loop_cfg,
    input  wire logic [NSERDES*SDR_W-1:0]   serdes_ratio_field,
    input  wire logic [LDIV_W-1:0]          local_bus_divider,
    // PLL controls
    output logic [NPLL-1:0]                 pll_enable,
    output logic [RATIO_W-1:0]              platform_mult,
    output logic [RATIO_W-1:0]              cluster1_mult,
    output logic [RATIO_W-1:0]              cluster2_mult,
    output logic [1:0]                      platform_loop,
    output logic [1:0]                      cluster1_loop,
    output logic [1:0]                      cluster2_loop,
    output logic [RATIO_W-1:0]              memory_mult,
    output logic [1:0]                      memory_loop,
    output logic                            memory_ref_platform,
    output logic                            memory_bus_half_plat,
    output logic [NSERDES*6-1:0]            serdes_mult,
    // Core clock routing
    output logic [NCORE-1:0]                core_use_second,
    output logic [NCORE-1:0]                core_div2,
    output logic [NCORE-1:0]                core_enable,
    // Derived clock enables
    output logic                            local_bus_tick,
    output logic                            pme_tick,
    // Status
    output logic                            config_error,
    output logic                            config_done
);

    // ****************************************
    // Field decode
    // ****************************************
    wire plat_ok = platform_ratio_field >= PLAT_MIN &&
                   platform_ratio_field <= PLAT_MAX;
    wire clu1_ok = cluster1_ratio_field >= CLU_MIN &&
                   cluster1_ratio_field <= CLU_MAX;
    wire clu2_ok = cluster2_ratio_field >= CLU_MIN &&
                   cluster2_ratio_field <= CLU_MAX;
    // Async ratios 5,6,8,9,10,12,13,16,18,20 only
    wire [4:0] mr = memory_ratio_field;
    wire mem_async_ok = mr == 5'h05 || mr == 5'h06 || mr == 5'h08 ||
                        mr == 5'h09 || mr == 5'h0A || mr == 5'h0C ||
                        mr == 5'h0D || mr == 5'h10 || mr == 5'h12 ||
                        mr == MEM_MAX;
    wire mem_sync_ok  = mr == MEM_SYNC_1TO1;
    wire mem_ok = ddr_sync_select ? mem_sync_ok : mem_async_ok;

    logic [NCORE-1:0] sel_ok;
    logic [NCORE-1:0] sel_second;
    logic [NCORE-1:0] sel_div2;
    logic [NSERDES-1:0] sd_ok;
    logic [NSERDES*6-1:0] sd_mult;

    genvar gi;
    generate
        for (gi = 0; gi < NCORE; gi++) begin : g_core
            wire [3:0] s = core_clock_select[gi*SEL_W +: SEL_W];
            if (gi < 2) begin : g_low
                assign sel_ok[gi] = s == SEL_C1_D1 || s == SEL_C1_D2 ||
                                    s == SEL_C2_D1;
            end else begin : g_high
                assign sel_ok[gi] = s == SEL_C1_D1 || s == SEL_C2_D1 ||
                                    s == SEL_C2_D2;
            end
            assign sel_second[gi] = s == SEL_C2_D1 || s == SEL_C2_D2;
            assign sel_div2[gi]   = s == SEL_C1_D2 || s == SEL_C2_D2;
        end
        for (gi = 0; gi < NSERDES; gi++) begin : g_sd
            wire [2:0] r = serdes_ratio_field[gi*SDR_W +: SDR_W];
            // Multiplier table per link; bank 0 lacks some ratios
            assign sd_mult[gi*6 +: 6] =
                (r == 3'h1 && gi != 0) ? 6'h14 :
                (r == 3'h2)            ? 6'h19 :
                (r == 3'h3)            ? 6'h28 :
                (r == 3'h4)            ? 6'h32 :
                (r == 3'h5 && gi != 0) ? 6'h18 :
                (r == 3'h6 && gi != 0) ? 6'h1E : 6'h00;
            assign sd_ok[gi] = sd_mult[gi*6 +: 6] != 6'h00;
        end
    endgenerate

    // Core enabled only if its source cluster PLL also decoded
    wire [NCORE-1:0] next_core_en;
    generate
        for (gi = 0; gi < NCORE; gi++) begin : g_cen
            assign next_core_en[gi] = sel_ok[gi] &&
                (sel_second[gi] ? clu2_ok : clu1_ok);
        end
    endgenerate

    // Memory PLL also needs the platform when sync
    wire mem_en = mem_ok && (!ddr_sync_select || plat_ok);
    // Order: cluster1, cluster2, platform, memory, serdes[1:0]
    // Six enable bits only; link 2 shows through config_error
    wire [NPLL-1:0] next_pll_en = {sd_ok[1:0], mem_en, plat_ok,
                                   clu2_ok, clu1_ok};
    wire next_err = !(plat_ok && clu1_ok && clu2_ok && mem_ok &&
                      &sel_ok && &sd_ok);

    // ****************************************
    // Power-up latch sequence
    // ****************************************
    pcd_state_type state;
    pcd_state_type next_state;
    assign next_state = (state == ST_IDLE && config_valid) ? ST_LATCH :
                        (state == ST_LATCH) ? ST_RUN : state;
    wire latch = state == ST_LATCH;
    wire run   = state == ST_RUN;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Fields other than local_bus_divider captured once; later changes ignored until reset
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pll_enable           <= '0;
            platform_mult        <= '0;
            cluster1_mult        <= '0;
            cluster2_mult        <= '0;
            platform_loop        <= LOOP_LOW;
            cluster1_loop        <= LOOP_LOW;
            cluster2_loop        <= LOOP_LOW;
            memory_mult          <= '0;
            memory_loop          <= LOOP_HIGH;
            memory_ref_platform  <= 1'b0;
            memory_bus_half_plat <= 1'b0;
            serdes_mult          <= '0;
            core_use_second      <= '0;
            core_div2            <= '0;
            core_enable          <= '0;
            config_error         <= 1'b0;
            config_done          <= 1'b0;
        end else if (latch) begin
            pll_enable           <= next_pll_en;
            platform_mult        <= plat_ok ? platform_ratio_field
                                            : 5'h00;
            cluster1_mult        <= clu1_ok ? cluster1_ratio_field
                                            : 5'h00;
            cluster2_mult        <= clu2_ok ? cluster2_ratio_field
                                            : 5'h00;
            platform_loop        <= platform_loop_cfg;
            cluster1_loop        <= cluster1_loop_cfg;
            cluster2_loop        <= cluster2_loop_cfg;
            memory_mult          <= mem_ok ? mr : 5'h00;
            memory_loop          <= memory_loop_cfg;
            memory_ref_platform  <= ddr_sync_select;
            memory_bus_half_plat <= ddr_sync_select && mem_ok;
            serdes_mult          <= sd_mult;
            core_use_second      <= sel_second;
            core_div2            <= sel_div2;
            core_enable          <= next_core_en;
            config_error         <= next_err;
            config_done          <= 1'b1;
        end
    end

    // ****************************************
    // Derived clock enables
    // ****************************************
    // Divider zero is treated as stopped, not as divide by 32
    localparam int PLAT_EN_BIT = 2;
    // Latched enable, so later ratio field changes cannot stop the ticks
    wire plat_run = run && pll_enable[PLAT_EN_BIT];

    pcd_clk_div u_lbc_div (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .run     (plat_run),
        .divisor (local_bus_divider),
        .tick    (local_bus_tick)
    );

    pcd_clk_div u_pme_div (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .run     (plat_run),
        .divisor (PME_DIV),
        .tick    (pme_tick)
    );

endmodule

// File: testbench/pcd_decode_sva.sv
// Assertions on the PLL ratio decoder ports.
// Assumes fields hold steady while the decoder latches them.
`timescale 1ns/10ps
module pcd_decode_chk
    import pcd_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    // Fields
    input wire logic [4:0]  platform_ratio_field,
    input wire logic [4:0]  cluster1_ratio_field,
    input wire logic [15:0] core_clock_select,
    input wire logic [4:0]  local_bus_divider,
    // Outputs
    input wire logic [5:0]  pll_enable,
    input wire logic [4:0]  platform_mult,
    input wire logic [4:0]  cluster1_mult,
    input wire logic [3:0]  core_use_second,
    input wire logic [3:0]  core_div2,
    input wire logic [3:0]  core_enable,
    input wire logic        local_bus_tick,
    input wire logic        pme_tick,
    input wire logic        config_error,
    input wire logic        config_done
);
    // ****************************************
    // Checks
    // ****************************************
    wire p_ok = platform_ratio_field inside {[5'h04:5'h0A]};
    wire c_ok = cluster1_ratio_field inside {[5'h08:5'h12]};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    plat_ratio_a: assert property ($rose(config_done) |->
        platform_mult == (p_ok ? platform_ratio_field : 5'h00))
        else $error("platform ratio wrong");
    clu_ratio_a: assert property ($rose(config_done) |->
        cluster1_mult == (c_ok ? cluster1_ratio_field : 5'h00))
        else $error("cluster ratio wrong");
    core_sel_a: assert property ($rose(config_done) && c_ok &&
        core_clock_select[3:0] == 4'h1 |-> core_enable[0] &&
        core_div2[0] && !core_use_second[0]) else $error("core select");
    plat_err_a: assert property ($rose(config_done) && !p_ok |->
        config_error && !pll_enable[2]) else $error("platform error");
    clu_err_a: assert property ($rose(config_done) && !c_ok |->
        config_error && !pll_enable[0]) else $error("cluster error");
    pme_rate_a: assert property (pme_tick |=> !pme_tick ##1 pme_tick)
        else $error("pattern engine tick rate");
    lb_rate_a: assert property (local_bus_tick &&
        local_bus_divider == 5'h03 |=> !local_bus_tick [*2] ##1
        local_bus_tick) else $error("local bus tick rate");
    hold_val_a: assert property (config_done && $past(config_done) |->
        $stable(platform_mult) && $stable(cluster1_mult))
        else $error("latched ratio moved");
endmodule
bind pcd_decode pcd_decode_chk u_chk (.clk_sys, .rstn,
    .platform_ratio_field, .cluster1_ratio_field, .core_clock_select,
    .local_bus_divider, .pll_enable, .platform_mult, .cluster1_mult,
    .core_use_second, .core_div2, .core_enable, .local_bus_tick,
    .pme_tick, .config_error, .config_done);

// File: testbench/pcd_cfg_src.sv
// Configuration source model: loop and memory mode fields.
// Assumes the bench sets the targets well before each latch.
`timescale 1ns/10ps
module pcd_cfg_src (
    // Clock and targets
    input  wire logic       clk_sys,
    input  wire logic [2:0] fast,
    input  wire logic       sync_mode,
    // Fields to the decoder
    output logic [1:0]      platform_loop_cfg = 2'h1,
    output logic [1:0]      cluster1_loop_cfg = 2'h1,
    output logic [1:0]      cluster2_loop_cfg = 2'h1,
    output logic [1:0]      memory_loop_cfg = 2'h0,
    output logic            ddr_sync_select = 1'b0
);
    always @(posedge clk_sys) begin
        platform_loop_cfg <= 2'h1;
        cluster1_loop_cfg <= fast[0] ? 2'h0 : 2'h1;
        cluster2_loop_cfg <= fast[1] ? 2'h0 : 2'h1;
        memory_loop_cfg <= fast[2] ? 2'h1 : 2'h0;
        ddr_sync_select <= sync_mode;
    end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the PLL ratio decoder.
// Assumes one latch per reset and a 100 MHz clock.
`timescale 1ns/10ps
module tb_top;
    logic        clk_sys, rstn, config_valid, sync_mode, ddr_sync_select;
    logic        memory_ref_platform, memory_bus_half_plat, config_done;
    logic        local_bus_tick, pme_tick, config_error;
    logic [4:0]  platform_ratio_field, cluster1_ratio_field, memory_mult;
    logic [4:0]  cluster2_ratio_field, memory_ratio_field, platform_mult;
    logic [4:0]  local_bus_divider, cluster1_mult, cluster2_mult;
    logic [1:0]  platform_loop_cfg, cluster1_loop_cfg, cluster2_loop_cfg;
    logic [1:0]  memory_loop_cfg, platform_loop, cluster1_loop;
    logic [1:0]  cluster2_loop, memory_loop;
    logic [15:0] core_clock_select;
    logic [8:0]  serdes_ratio_field;
    logic [17:0] serdes_mult;
    logic [5:0]  pll_enable;
    logic [3:0]  core_use_second, core_div2, core_enable;
    logic [2:0]  fast;
    int          fail_count, samples_checked;

    pcd_cfg_src src (.clk_sys, .fast, .sync_mode, .platform_loop_cfg,
        .cluster1_loop_cfg, .cluster2_loop_cfg, .memory_loop_cfg,
        .ddr_sync_select);
    pcd_decode dut (.clk_sys, .rstn, .config_valid, .platform_ratio_field,
        .platform_loop_cfg, .cluster1_ratio_field, .cluster2_ratio_field,
        .cluster1_loop_cfg, .cluster2_loop_cfg, .core_clock_select,
        .ddr_sync_select, .memory_ratio_field, .memory_loop_cfg,
        .serdes_ratio_field, .local_bus_divider, .pll_enable, .platform_mult,
        .cluster1_mult, .cluster2_mult, .platform_loop, .cluster1_loop,
        .cluster2_loop, .memory_mult, .memory_loop, .memory_ref_platform,
        .memory_bus_half_plat, .serdes_mult, .core_use_second, .core_div2,
        .core_enable, .local_bus_tick, .pme_tick, .config_error,
        .config_done);

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [5:0] sdx(input logic [2:0] c, input logic w);
        case (c)
            3'h2: return 6'h19;
            3'h3: return 6'h28;
            3'h4: return 6'h32;
            3'h1: return w ? 6'h14 : 6'h00;
            3'h5: return w ? 6'h18 : 6'h00;
            3'h6: return w ? 6'h1E : 6'h00;
            default: return 6'h00;
        endcase
    endfunction

    // One reset, then fields held while the decoder takes them
    task automatic latch(input logic [4:0] p, c1, c2, m,
                         input logic [15:0] s, input logic [8:0] d);
        int i;
        @(posedge clk_sys);
        rstn <= 1'b0;
        config_valid <= 1'b0;
        @(posedge clk_sys);
        platform_ratio_field <= p;
        cluster1_ratio_field <= c1;
        cluster2_ratio_field <= c2;
        memory_ratio_field <= m;
        core_clock_select <= s;
        serdes_ratio_field <= d;
        rstn <= 1'b1;
        config_valid <= 1'b1;
        // Let the reset edge land before polling the done flag
        @(posedge clk_sys);
        #1;
        for (i = 0; i < 20 && config_done !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (config_done !== 1'b1) begin
            fail_count++;
            end_sim();
        end
    endtask

    task automatic t_basic;
        int np, nl;
        fast <= 3'b101;
        sync_mode <= 1'b0;
        // Core rates kept at or above platform
        latch(5'h06, 5'h0C, 5'h12, 5'h0C, 16'h0541, 9'h1AA);
        chk(platform_mult, 5'h06);
        chk({cluster1_mult, cluster2_mult}, 10'h192);
        chk(memory_mult, 5'h0C);
        chk(memory_ref_platform, 1'b0);
        chk(serdes_mult, {6'h1E, 6'h18, 6'h19});
        chk(pll_enable, 6'h3F);
        chk({core_use_second, core_div2}, 8'h65);
        chk({core_enable, config_error}, 5'h1E);
        chk({platform_loop, cluster1_loop, cluster2_loop, memory_loop},
            8'h45);
        repeat (10) @(posedge clk_sys);
        np = 0;
        nl = 0;
        repeat (30) begin
            @(posedge clk_sys);
            #1;
            np += (pme_tick === 1'b1);
            nl += (local_bus_tick === 1'b1);
        end
        chk(np, 15);
        chk(nl, 10);
        @(posedge clk_sys);
        platform_ratio_field <= 5'h05;
        cluster1_ratio_field <= 5'h09;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({platform_mult, cluster1_mult}, 10'h0CC);
        $display("basic test done");
    endtask

    task automatic t_sync;
        sync_mode <= 1'b1;
        latch(5'h04, 5'h08, 5'h08, 5'h01, 16'h0000, 9'h1AA);
        chk({memory_ref_platform, memory_bus_half_plat}, 2'b11);
        chk({memory_mult, pll_enable[3], config_error}, 7'h06);
        latch(5'h04, 5'h08, 5'h08, 5'h05, 16'h0000, 9'h1AA);
        chk({pll_enable[3], config_error}, 2'b01);
        // Sync memory PLL needs a valid platform reference
        latch(5'h0B, 5'h08, 5'h08, 5'h01, 16'h0000, 9'h1AA);
        chk({pll_enable[3:2], config_error}, 3'b001);
        sync_mode <= 1'b0;
        latch(5'h0B, 5'h07, 5'h08, 5'h01, 16'h4105, 9'h091);
        chk({platform_mult, cluster1_mult}, 10'h000);
        chk(pll_enable[3:0], 4'b0010);
        chk(core_enable, 4'b1000);
        chk({serdes_mult[5:0], config_error}, 7'h01);
        $display("mode and reserved test done");
    endtask

    task automatic t_codes;
        logic [4:0] k;
        for (k = 5'h03; k <= 5'h13; k++) begin
            latch(k, k, 5'h08, 5'h0C, 16'h0000, {3{k[2:0]}});
            chk(platform_mult, (k >= 5'h04 && k <= 5'h0A) ? k : 5'h00);
            chk(cluster1_mult, (k >= 5'h08 && k <= 5'h12) ? k : 5'h00);
            chk(serdes_mult, {sdx(k[2:0], 1'b1), sdx(k[2:0], 1'b1),
                sdx(k[2:0], 1'b0)});
        end
        $display("code sweep test done");
    endtask

    // Divider set to 5 under reset, later cut to 0 while running; no rate check spans either change
    task automatic t_lbdiv;
        int nl;
        @(posedge clk_sys);
        rstn <= 1'b0;
        local_bus_divider <= 5'h05;
        latch(5'h06, 5'h0C, 5'h0C, 5'h0C, 16'h0000, 9'h092);
        repeat (10) @(posedge clk_sys);
        nl = 0;
        repeat (30) begin
            @(posedge clk_sys);
            #1;
            nl += (local_bus_tick === 1'b1);
        end
        chk(nl, 6);
        @(posedge clk_sys);
        local_bus_divider <= 5'h00;
        nl = 0;
        repeat (20) begin
            @(posedge clk_sys);
            #1;
            nl += (local_bus_tick === 1'b1);
        end
        chk(nl, 0);
        $display("local bus divider test done");
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        rstn = 1'b0;
        config_valid = 1'b0;
        fast = 3'b000;
        sync_mode = 1'b0;
        platform_ratio_field = 5'h00;
        cluster1_ratio_field = 5'h00;
        cluster2_ratio_field = 5'h00;
        memory_ratio_field = 5'h00;
        core_clock_select = 16'h0000;
        serdes_ratio_field = 9'h000;
        local_bus_divider = 5'h03;
        fail_count = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk_sys);
        t_basic();
        t_sync();
        t_lbdiv();
        t_codes();
        end_sim();
    end
endmodule
